//--- verilog/unary_ops_pkg.sv
// package for the file-register unary operation datapath
// assumes one core instruction clock and a combinational register-file read
package unary_ops_pkg;

	// widths of data and of the in-bank register address
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;

	// reset and constant values
	localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ONE   = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
	localparam logic              Z_RESET    = 1'b0;

	// operations handled by this block
	typedef enum logic [2:0] {
		complement_reg_op,
		clear_reg_op,
		decrement_reg_op,
		clear_accumulator_op,
		decrement_skip_zero_op,
		increment_skip_zero_op
	} op_e;

	// true for the two operations that may discard the next instruction
	function automatic logic op_is_skip(input op_e op);
		op_is_skip = (op == decrement_skip_zero_op) || (op == increment_skip_zero_op);
	endfunction : op_is_skip

endpackage : unary_ops_pkg

//--- verilog/alu_link_if.sv
// carrier between the datapath top and its arithmetic unit
// assumes the top drives op and operand and reads the rest
interface alu_link_if #(
	parameter int DW = unary_ops_pkg::DATA_W
);
	unary_ops_pkg::op_e op;
	logic [DW-1:0]      operand;
	logic [DW-1:0]      result;
	logic               res_zero;
	logic               z_update;
	logic               skip_req;
	logic               force_reg;
	logic               force_acc;

	// top side issues, unit side computes
	modport top  (output op, operand, input result, res_zero, z_update, skip_req,
		force_reg, force_acc);
	modport unit (input op, operand, output result, res_zero, z_update, skip_req,
		force_reg, force_acc);
endinterface : alu_link_if

//--- verilog/unary_alu.sv
// combinational arithmetic unit for the unary file-register operations
// assumes operand is the addressed register value, valid in the same cycle
module unary_alu
	import unary_ops_pkg::*;
#(
	parameter int DATA_W = unary_ops_pkg::DATA_W
) (
	alu_link_if.unit lnk
);

	// result per operation
	always_comb begin
		lnk.result    = lnk.operand;
		lnk.z_update  = 1'b0;
		lnk.force_reg = 1'b0;
		lnk.force_acc = 1'b0;
		case (lnk.op)
			complement_reg_op: begin
				lnk.result   = ~lnk.operand;
				lnk.z_update = 1'b1;
			end
			clear_reg_op: begin
				lnk.result    = DATA_ZERO;
				lnk.z_update  = 1'b1;
				lnk.force_reg = 1'b1;
			end
			decrement_reg_op: begin
				lnk.result   = DATA_W'(lnk.operand - DATA_ONE);
				lnk.z_update = 1'b1;
			end
			clear_accumulator_op: begin
				lnk.result    = DATA_ZERO;
				lnk.z_update  = 1'b1;
				lnk.force_acc = 1'b1;
			end
			decrement_skip_zero_op: begin
				lnk.result = DATA_W'(lnk.operand - DATA_ONE);
			end
			increment_skip_zero_op: begin
				lnk.result = DATA_W'(lnk.operand + DATA_ONE);
			end
			default: begin
				lnk.result = lnk.operand;
			end
		endcase
	end

	// zero detect and skip request
	assign lnk.res_zero = (lnk.result == DATA_ZERO);
	assign lnk.skip_req = op_is_skip(lnk.op);

endmodule : unary_alu

//--- verilog/file_register_unary_ops.sv
// datapath top for single-operand file-register operations with skip-on-zero
// assumes a decoder presents op/reg_addr/dest_sel with op_valid and a
// register file that returns reg_rdata combinationally for reg_raddr
//
// Contract
// - Complement gives the bitwise inverse of the register, written to the accumulator when dest is 0.
// - Complement with dest 1 writes the result back to the addressed register instead.
// - Clear-register writes zero to the addressed register and sets the zero flag.
// - Decrement subtracts one and routes the result by dest to accumulator or register.
// - Clear-accumulator takes no operand, zeroes the accumulator and sets the zero flag.
// - Decrement-and-skip subtracts one and stores the result by dest.
// - A zero result of decrement-and-skip turns the next instruction into a no-op.
// - Increment-and-skip adds one and stores the result by dest.
// - A zero result of increment-and-skip turns the next instruction into a no-op.
module file_register_unary_ops
	import unary_ops_pkg::*;
#(
	parameter int DATA_W = unary_ops_pkg::DATA_W,
	parameter int ADDR_W = unary_ops_pkg::ADDR_W
) (
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire logic               op_valid,
	output logic                    op_ready,
	input  wire unary_ops_pkg::op_e op_code,
	input  wire logic [ADDR_W-1:0]  reg_addr,
	input  wire logic               dest_sel,
	output logic [ADDR_W-1:0]       reg_raddr,
	input  wire logic [DATA_W-1:0]  reg_rdata,
	output logic                    reg_we,
	output logic [ADDR_W-1:0]       reg_waddr,
	output logic [DATA_W-1:0]       reg_wdata,
	output logic [DATA_W-1:0]       acc_q,
	output logic                    zero_flag,
	output logic                    discard_next
);
	import unary_ops_pkg::*;

	alu_link_if #(.DW(DATA_W)) lnk ();

	logic [DATA_W-1:0] acc_r;
	logic [DATA_W-1:0] acc_nxt;
	logic              zero_r;
	logic              zero_nxt;
	logic              reg_we_r;
	logic [ADDR_W-1:0] reg_waddr_r;
	logic [DATA_W-1:0] reg_wdata_r;
	logic              skip_r;
	logic              skip_nxt;

	// arithmetic unit
	unary_alu #(.DATA_W(DATA_W)) u_alu (
		.lnk (lnk)
	);

	// operand fetch: address passes straight to the register file
	assign reg_raddr   = reg_addr;
	assign lnk.op      = op_code;
	assign lnk.operand = reg_rdata;

	// the cycle after a zero skip result is the discarded slot
	wire take = op_valid && op_ready;
	assign op_ready = !skip_r;

	// destination routing
	wire to_reg = take && (lnk.force_reg || (!lnk.force_acc && dest_sel));
	wire to_acc = take && (lnk.force_acc || (!lnk.force_reg && !dest_sel));

	// next-state values
	assign acc_nxt  = to_acc ? lnk.result : acc_r;
	assign zero_nxt = (take && lnk.z_update) ? lnk.res_zero : zero_r;
	assign skip_nxt = take && lnk.skip_req && lnk.res_zero;

	// accumulator and zero flag
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acc_r  <= ACC_RESET;
			zero_r <= Z_RESET;
		end else begin
			acc_r  <= acc_nxt;
			zero_r <= zero_nxt;
		end
	end

	// register write-back port, one-cycle strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_we_r    <= 1'b0;
			reg_waddr_r <= ADDR_RESET;
			reg_wdata_r <= DATA_ZERO;
		end else begin
			reg_we_r <= to_reg;
			if (to_reg) begin
				reg_waddr_r <= reg_addr;
				reg_wdata_r <= lnk.result;
			end
		end
	end

	// skip slot marker
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			skip_r <= 1'b0;
		end else begin
			skip_r <= skip_nxt;
		end
	end

	// outputs from flip-flops
	assign acc_q        = acc_r;
	assign zero_flag    = zero_r;
	assign reg_we       = reg_we_r;
	assign reg_waddr    = reg_waddr_r;
	assign reg_wdata    = reg_wdata_r;
	assign discard_next = skip_r;

	// checks
	sequence s_take(op_e o, logic d);
		take && op_code == o && dest_sel == d;
	endsequence

	sequence s_skip_slot;
		skip_r && !op_ready ##1 !skip_r && op_ready;
	endsequence

	property p_comp_acc;
		@(posedge ref_clk) disable iff (rst)
		s_take(complement_reg_op, 1'b0) |=>
			acc_q == ~$past(reg_rdata) && !reg_we && zero_flag == (acc_q == DATA_ZERO);
	endproperty
	a_comp_acc: assert property (p_comp_acc)
		else $error("complement to accumulator wrong");

	property p_comp_reg;
		@(posedge ref_clk) disable iff (rst)
		s_take(complement_reg_op, 1'b1) |=>
			reg_we && reg_wdata == ~$past(reg_rdata) && $stable(acc_q);
	endproperty
	a_comp_reg: assert property (p_comp_reg)
		else $error("complement write-back wrong");

	property p_clear_reg;
		@(posedge ref_clk) disable iff (rst)
		take && op_code == clear_reg_op |=>
			reg_we && reg_wdata == DATA_ZERO && zero_flag && $stable(acc_q);
	endproperty
	a_clear_reg: assert property (p_clear_reg)
		else $error("clear register wrong");

	property p_dec;
		@(posedge ref_clk) disable iff (rst)
		take && op_code == decrement_reg_op |=>
			($past(dest_sel) ? (reg_we && reg_wdata == DATA_W'($past(reg_rdata) - DATA_ONE))
			: (acc_q == DATA_W'($past(reg_rdata) - DATA_ONE)));
	endproperty
	a_dec: assert property (p_dec)
		else $error("decrement result wrong");

	property p_clear_acc;
		@(posedge ref_clk) disable iff (rst)
		take && op_code == clear_accumulator_op |=> acc_q == DATA_ZERO && zero_flag && !reg_we;
	endproperty
	a_clear_acc: assert property (p_clear_acc)
		else $error("clear accumulator wrong");

	property p_decs_store;
		@(posedge ref_clk) disable iff (rst)
		s_take(decrement_skip_zero_op, 1'b1) |=>
			reg_we && reg_wdata == DATA_W'($past(reg_rdata) - DATA_ONE);
	endproperty
	a_decs_store: assert property (p_decs_store)
		else $error("decrement-skip store wrong");

	property p_decs_skip;
		@(posedge ref_clk) disable iff (rst)
		take && op_code == decrement_skip_zero_op && reg_rdata == DATA_ONE |=> s_skip_slot;
	endproperty
	a_decs_skip: assert property (p_decs_skip)
		else $error("decrement-skip did not discard one slot");

	property p_incs_store;
		@(posedge ref_clk) disable iff (rst)
		s_take(increment_skip_zero_op, 1'b0) |=>
			acc_q == DATA_W'($past(reg_rdata) + DATA_ONE) && !reg_we;
	endproperty
	a_incs_store: assert property (p_incs_store)
		else $error("increment-skip store wrong");

	property p_incs_skip;
		@(posedge ref_clk) disable iff (rst)
		take && op_code == increment_skip_zero_op |=>
			discard_next == (DATA_W'($past(reg_rdata) + DATA_ONE) == DATA_ZERO);
	endproperty
	a_incs_skip: assert property (p_incs_skip)
		else $error("increment-skip decision does not match zero result");

	property p_skip_flags;
		@(posedge ref_clk) disable iff (rst)
		take && op_is_skip(op_code) |=> $stable(zero_flag);
	endproperty
	a_skip_flags: assert property (p_skip_flags)
		else $error("skip operation changed zero flag");

	property p_dec_zero;
		@(posedge ref_clk) disable iff (rst)
		take && op_code == decrement_reg_op |=>
			zero_flag == (DATA_W'($past(reg_rdata) - DATA_ONE) == DATA_ZERO);
	endproperty
	a_dec_zero: assert property (p_dec_zero)
		else $error("decrement did not update zero flag");

	property p_slot_refused;
		@(posedge ref_clk) disable iff (rst)
		skip_r |=> !reg_we && $stable(acc_q) && $stable(zero_flag);
	endproperty
	a_slot_refused: assert property (p_slot_refused)
		else $error("discarded slot changed state");

	property p_waddr;
		@(posedge ref_clk) disable iff (rst)
		take && dest_sel && op_code != clear_accumulator_op |=> reg_waddr == $past(reg_addr);
	endproperty
	a_waddr: assert property (p_waddr)
		else $error("write address not the operand address");

endmodule : file_register_unary_ops

//--- testbench/reg_file_model.sv
// behavioural data register file standing behind the datapath
// assumes reads are combinational and writes land on the rising edge
module reg_file_model
	import unary_ops_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic [ADDR_W-1:0] raddr,
	output logic      [DATA_W-1:0] rdata,
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] waddr,
	input  wire logic [DATA_W-1:0] wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DATA_W-1:0] mem [128];
	// read path the datapath samples in its request cycle
	assign rdata = mem[raddr];
	// one write per strobe
	always @(posedge ref_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end
endmodule : reg_file_model

//--- testbench/file_register_unary_ops_tb.sv
// self-checking bench for the unary file-register datapath
// assumes the register file model answers reads in the same cycle
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
	$display("wrong value t=%0t got %h exp %h", $time, got, exp); end end
module file_register_unary_ops_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import unary_ops_pkg::*;
	logic              ref_clk = 1'b0;
	logic              rst = 1'b1;
	logic              op_valid = 1'b0;
	op_e               op_code = complement_reg_op;
	logic [ADDR_W-1:0] reg_addr = 7'h00;
	logic              dest_sel = 1'b0;
	logic              op_ready, reg_we, zero_flag, discard_next;
	logic [ADDR_W-1:0] reg_raddr, reg_waddr;
	logic [DATA_W-1:0] reg_rdata, reg_wdata, acc_q;
	int                failures = 0;
	int                comparisons = 0;
	// 25 MHz instruction clock
	always #20 ref_clk = ~ref_clk;
	file_register_unary_ops uut (.ref_clk(ref_clk), .rst(rst), .op_valid(op_valid),
		.op_ready(op_ready), .op_code(op_code), .reg_addr(reg_addr), .dest_sel(dest_sel),
		.reg_raddr(reg_raddr), .reg_rdata(reg_rdata), .reg_we(reg_we),
		.reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .acc_q(acc_q),
		.zero_flag(zero_flag), .discard_next(discard_next));
	reg_file_model rf (.ref_clk(ref_clk), .raddr(reg_raddr), .rdata(reg_rdata),
		.we(reg_we), .waddr(reg_waddr), .wdata(reg_wdata));
	// present one op at a falling edge, leave it up, return one cycle later
	task automatic run_op(input op_e op, input logic [ADDR_W-1:0] a, input logic d);
		op_valid = 1'b1;
		op_code = op;
		reg_addr = a;
		dest_sel = d;
		@(negedge ref_clk);
	endtask : run_op
	task automatic idle();
		op_valid = 1'b0;
		@(negedge ref_clk);
	endtask : idle
	// complement to either destination
	task automatic t_complement();
		rf.mem[5] = 8'hff;
		rf.mem[6] = 8'h5a;
		run_op(complement_reg_op, 7'h05, 1'b0);
		`CHK(acc_q, 8'h00)
		`CHK(zero_flag, 1'b1)
		`CHK(reg_we, 1'b0)
		run_op(complement_reg_op, 7'h06, 1'b1);
		`CHK({reg_we, reg_waddr, reg_wdata}, {1'b1, 7'h06, 8'ha5})
		`CHK({acc_q, zero_flag}, {8'h00, 1'b0})
		idle();
	endtask : t_complement
	// clears and plain decrement, back to back
	task automatic t_clear_dec();
		rf.mem[10] = 8'h00;
		rf.mem[11] = 8'h01;
		rf.mem[12] = 8'h05;
		run_op(decrement_reg_op, 7'h0a, 1'b0);
		`CHK({acc_q, zero_flag}, {8'hff, 1'b0})
		run_op(clear_reg_op, 7'h7f, 1'b0);
		`CHK({reg_we, reg_waddr, reg_wdata}, {1'b1, 7'h7f, 8'h00})
		`CHK({acc_q, zero_flag}, {8'hff, 1'b1})
		run_op(decrement_reg_op, 7'h0b, 1'b1);
		`CHK({reg_we, reg_waddr, reg_wdata}, {1'b1, 7'h0b, 8'h00})
		run_op(decrement_reg_op, 7'h0c, 1'b0);
		`CHK({acc_q, zero_flag, reg_we}, {8'h04, 1'b0, 1'b0})
		run_op(clear_accumulator_op, 7'h0c, 1'b1);
		`CHK({acc_q, zero_flag, reg_we}, {8'h00, 1'b1, 1'b0})
		idle();
	endtask : t_clear_dec
	// skip forms: zero and nonzero results, refused slot
	task automatic t_skip();
		rf.mem[20] = 8'h01;
		rf.mem[21] = 8'hff;
		rf.mem[22] = 8'h7f;
		rf.mem[23] = 8'h02;
		rf.mem[24] = 8'h33;
		run_op(decrement_skip_zero_op, 7'h17, 1'b0);
		`CHK({acc_q, zero_flag, discard_next}, {8'h01, 1'b1, 1'b0})
		run_op(complement_reg_op, 7'h18, 1'b1);
		`CHK(zero_flag, 1'b0)
		run_op(decrement_skip_zero_op, 7'h14, 1'b1);
		`CHK({reg_we, reg_waddr, reg_wdata}, {1'b1, 7'h14, 8'h00})
		`CHK({discard_next, op_ready, zero_flag}, {1'b1, 1'b0, 1'b0})
		run_op(complement_reg_op, 7'h17, 1'b0);
		`CHK({acc_q, reg_we, discard_next}, {8'h01, 1'b0, 1'b0})
		run_op(increment_skip_zero_op, 7'h15, 1'b0);
		`CHK({acc_q, discard_next, zero_flag}, {8'h00, 1'b1, 1'b0})
		idle();
		`CHK({discard_next, op_ready}, {1'b0, 1'b1})
		run_op(increment_skip_zero_op, 7'h16, 1'b1);
		`CHK({reg_we, reg_wdata, discard_next}, {1'b1, 8'h80, 1'b0})
		idle();
	endtask : t_skip
	// mid-run reset with a write and a skip pending, then a request at the first edge
	task automatic t_reset();
		rf.mem[30] = 8'h0f;
		rf.mem[31] = 8'h01;
		rf.mem[32] = 8'h41;
		run_op(complement_reg_op, 7'h1e, 1'b0);
		run_op(decrement_skip_zero_op, 7'h1f, 1'b1);
		`CHK({acc_q, reg_we, discard_next}, {8'hf0, 1'b1, 1'b1})
		op_valid = 1'b0;
		rst = 1'b1;
		@(negedge ref_clk);
		`CHK({acc_q, zero_flag}, {ACC_RESET, Z_RESET})
		`CHK({reg_waddr, reg_wdata}, {ADDR_RESET, DATA_ZERO})
		`CHK({reg_we, discard_next, op_ready}, {1'b0, 1'b0, 1'b1})
		rst = 1'b0;
		run_op(decrement_reg_op, 7'h1f, 1'b1);
		`CHK({reg_we, reg_wdata, zero_flag, discard_next}, {1'b1, 8'h00, 1'b1, 1'b0})
		run_op(increment_skip_zero_op, 7'h20, 1'b0);
		`CHK({acc_q, zero_flag, reg_we, discard_next}, {8'h42, 1'b1, 1'b0, 1'b0})
		idle();
	endtask : t_reset
	task automatic wrap_up();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	// main sequence after three cycles of reset
	initial begin
		repeat (3) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		t_complement();
		t_clear_dec();
		t_skip();
		t_reset();
		wrap_up();
	end
	// hang guard
	initial begin
		repeat (500) @(posedge ref_clk);
		failures++;
		wrap_up();
	end
endmodule : file_register_unary_ops_tb
